// ==== inc/thm_pkg.sv ====
// Shared constants and types of the thermometer command core.
// Assumes a bit-slot layer outside that delivers slot events on i_clock.
//
// Behaviour
// - Read-identity 33h sends 64-bit identity code
// - Match-identity 55h compares code, selects on match
// - Skip-identity CCh selects device directly
// - Search F0h enumerates; ECh only when alarmed
// - Conversion starts only on command 44h
// - Read BEh sends working memory plus check
// - Write 4Eh stores bytes 2, 3, 4
// - Copy 48h saves limits, config to nonvolatile
// - Recall B8h reloads limits, config from nonvolatile
// - Power query B4h reports supply source
// - Resolution 9 to 12 bits selectable
// - Default resolution is 12 bits
// - Idle, not converting, after power-up
// - Result stored, then back to idle
// - External supply: poll reads 0 busy, 1 done
// - Signed 16-bit value, bit 0 weighs 1/16
// - Sign bits 1 for negative, two's complement
// - Low bits undefined below 12-bit resolution
// - Limits and config kept nonvolatile
// - Working memory byte layout, check byte 8
// - Resolution field in config bits 6:5
// - Conversion times 93.75 to 750 ms
package thm_pkg;

   // ==================================================================
   // Commands
   localparam logic [7:0] CMD_ID_READ   = 8'h33;
   localparam logic [7:0] CMD_ID_MATCH  = 8'h55;
   localparam logic [7:0] CMD_ID_SKIP   = 8'hCC;
   localparam logic [7:0] CMD_SEARCH    = 8'hF0;
   localparam logic [7:0] CMD_ALM_SRCH  = 8'hEC;
   localparam logic [7:0] CMD_CONVERT   = 8'h44;
   localparam logic [7:0] CMD_SP_READ   = 8'hBE;
   localparam logic [7:0] CMD_SP_WRITE  = 8'h4E;
   localparam logic [7:0] CMD_COPY      = 8'h48;
   localparam logic [7:0] CMD_RELOAD    = 8'hB8;
   localparam logic [7:0] CMD_PWR_QUERY = 8'hB4;

   // ==================================================================
   // Memory layout and reset values
   localparam int          RES_LSB      = 5;
   localparam logic [7:0]  CFG_RESET    = 8'h7F;
   localparam logic [7:0]  CFG_WR_MASK  = 8'h60;
   localparam logic [7:0]  UPPER_RESET  = 8'h4B;
   localparam logic [7:0]  LOWER_RESET  = 8'h46;
   localparam logic [7:0]  RSV_BYTE5    = 8'hFF;
   localparam logic [7:0]  RSV_BYTE6    = 8'h00;
   localparam logic [7:0]  RSV_BYTE7    = 8'h10;
   localparam logic [7:0]  CRC_POLY_REF = 8'h8C;
   localparam logic [15:0] TEMP_RESET   = 16'h0550;

   // ==================================================================
   // Timing
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned T_CONV12_US   = 750_000;
   localparam int unsigned CONV12_CYCLES = T_CONV12_US * CLK_MHZ;

   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] lower;
      logic [7:0] upper;
   } thm_nv_s;

   typedef enum logic [3:0] {
      ST_ROM    = 4'b0000,
      ST_ID_RD  = 4'b0001,
      ST_MATCH  = 4'b0010,
      ST_SEARCH = 4'b0011,
      ST_FUNC   = 4'b0100,
      ST_SP_RD  = 4'b0101,
      ST_SP_WR  = 4'b0110,
      ST_POLL   = 4'b0111,
      ST_PWR    = 4'b1000,
      ST_DEAD   = 4'b1001
   } thm_state_e;

endpackage

// ==== verilog/thm_core.sv ====
// Command decoder and conversion control of the thermometer.
// Slot events come from a bit layer on i_clock; samples from the sensor.
`timescale 1ns/1ns
module thm_core
   import thm_pkg::*;
#(
   parameter logic [63:0] P_ID_CODE     = 64'h0123_4567_89AB_CD28,
   parameter int unsigned P_CONV_CYCLES = CONV12_CYCLES
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // Bit-slot layer
   input  wire logic        i_bus_reset,
   input  wire logic        i_wr_slot,
   input  wire logic        i_wr_bit,
   input  wire logic        i_rd_slot,
   output logic             o_rd_bit,
   // Sensor and supply pin
   input  wire logic [15:0] i_sensor_temp,
   input  wire logic        i_ext_powered,
   // Status
   output logic             o_conv_busy,
   output logic [15:0]      o_temperature,
   output logic             o_alarm
);
   // P_ID_CODE value is arbitrary.

   // ==================================================================
   // Elaboration checks
   if (P_CONV_CYCLES < 8) begin : g_bad_conv
      $error("P_CONV_CYCLES too small");
   end

   function automatic logic [7:0] crc8(input logic [63:0] data);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ CRC_POLY_REF;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   // ==================================================================
   // State
   thm_state_e  state_q, state_d;
   logic [6:0]  cnt_q, cnt_d;
   logic [1:0]  phase_q, phase_d;
   logic [23:0] rx_q, rx_d;
   logic        busy_q, busy_d;
   logic [31:0] conv_q, conv_d;
   logic [15:0] temp_q, temp_d;
   thm_nv_s     sp_q, sp_d;
   thm_nv_s     nv_q, nv_d;
   logic        tx_q, tx_d;
   logic        ext_s1_q, ext_q;

   logic [1:0]  res;
   logic [7:0]  byte_in;
   logic [15:0] sample;
   logic [63:0] sp_vec;
   logic [7:0]  crc;
   logic        alarm;
   logic        conv_start;
   logic        copy_ev;
   logic        reload_ev;
   logic        wr_done;

   assign res     = sp_q.cfg[RES_LSB +: 2];
   assign byte_in = {i_wr_bit, rx_q[23:17]};

   // Force sign extension, then clear the bits the resolution leaves
   // undefined so a read always returns stable data.
   always_comb begin
      sample = {{5{i_sensor_temp[11]}}, i_sensor_temp[10:0]};
      sample = sample & ~(16'h0007 >> res);
   end

   assign sp_vec = {RSV_BYTE7, RSV_BYTE6, RSV_BYTE5,
                    sp_q.cfg, sp_q.lower, sp_q.upper,
                    temp_q};
   assign crc    = crc8(sp_vec);

   // Integer part of the result against signed limit bytes
   assign alarm = ($signed(temp_q[11:4]) >= $signed(sp_q.upper)) ||
                  ($signed(temp_q[11:4]) <= $signed(sp_q.lower));

   // ==================================================================
   // Command sequencing and conversion
   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      phase_d    = phase_q;
      rx_d       = rx_q;
      busy_d     = busy_q;
      conv_d     = conv_q;
      temp_d     = temp_q;
      sp_d       = sp_q;
      nv_d       = nv_q;
      conv_start = 1'b0;
      copy_ev    = 1'b0;
      reload_ev  = 1'b0;
      wr_done    = 1'b0;

      if (busy_q) begin
         if (conv_q <= 32'd1) begin
            busy_d = 1'b0;
            temp_d = sample;
         end else begin
            conv_d = conv_q - 32'd1;
         end
      end

      if (i_wr_slot) begin
         rx_d = {i_wr_bit, rx_q[23:1]};
      end

      if (i_bus_reset) begin
         state_d = ST_ROM;
         cnt_d   = '0;
         phase_d = '0;
      end else begin
         unique case (state_q)
            ST_ROM: if (i_wr_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == 7'd7) begin
                  cnt_d   = '0;
                  state_d = ST_DEAD;
                  unique case (byte_in)
                     CMD_ID_READ:  state_d = ST_ID_RD;
                     CMD_ID_MATCH: state_d = ST_MATCH;
                     CMD_ID_SKIP:  state_d = ST_FUNC;
                     CMD_SEARCH:   state_d = ST_SEARCH;
                     CMD_ALM_SRCH: state_d = alarm ? ST_SEARCH
                                                   : ST_DEAD;
                     default:      state_d = ST_DEAD;
                  endcase
               end
            end
            ST_ID_RD: if (i_rd_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == 7'd63) begin
                  cnt_d   = '0;
                  state_d = ST_FUNC;
               end
            end
            ST_MATCH: if (i_wr_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (i_wr_bit != P_ID_CODE[cnt_q[5:0]]) begin
                  state_d = ST_DEAD;
               end else if (cnt_q == 7'd63) begin
                  cnt_d   = '0;
                  state_d = ST_FUNC;
               end
            end
            ST_SEARCH: begin
               if (phase_q != 2'd2 && i_rd_slot) begin
                  phase_d = phase_q + 2'd1;
               end else if (phase_q == 2'd2 && i_wr_slot) begin
                  phase_d = '0;
                  cnt_d   = cnt_q + 7'd1;
                  if (i_wr_bit != P_ID_CODE[cnt_q[5:0]]) begin
                     state_d = ST_DEAD;
                  end else if (cnt_q == 7'd63) begin
                     cnt_d   = '0;
                     state_d = ST_FUNC;
                  end
               end
            end
            ST_FUNC: if (i_wr_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == 7'd7) begin
                  cnt_d   = '0;
                  state_d = ST_DEAD;
                  unique case (byte_in)
                     CMD_CONVERT: begin
                        conv_start = 1'b1;
                        busy_d     = 1'b1;
                        conv_d     = P_CONV_CYCLES >> (2'd3 - res);
                        state_d    = ST_POLL;
                     end
                     CMD_SP_READ:  state_d = ST_SP_RD;
                     CMD_SP_WRITE: state_d = ST_SP_WR;
                     CMD_COPY: begin
                        copy_ev = 1'b1;
                        nv_d    = sp_q;
                        state_d = ST_POLL;
                     end
                     CMD_RELOAD: begin
                        reload_ev = 1'b1;
                        sp_d      = nv_q;
                        state_d   = ST_POLL;
                     end
                     CMD_PWR_QUERY: state_d = ST_PWR;
                     default:       state_d = ST_DEAD;
                  endcase
               end
            end
            ST_SP_RD: if (i_rd_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == 7'd71) begin
                  state_d = ST_DEAD;
               end
            end
            ST_SP_WR: if (i_wr_slot) begin
               cnt_d = cnt_q + 7'd1;
               if (cnt_q == 7'd23) begin
                  wr_done     = 1'b1;
                  sp_d.upper  = rx_d[7:0];
                  sp_d.lower  = rx_d[15:8];
                  sp_d.cfg    = (CFG_RESET & ~CFG_WR_MASK) |
                                (rx_d[23:16] & CFG_WR_MASK);
                  state_d     = ST_DEAD;
               end
            end
            ST_POLL, ST_PWR, ST_DEAD: ;
            default: state_d = ST_DEAD;
         endcase
      end
   end

   // Next bit offered to the master's read slot
   always_comb begin
      tx_d = 1'b1;
      unique case (state_d)
         ST_ID_RD: tx_d = P_ID_CODE[cnt_d[5:0]];
         ST_SEARCH: begin
            if (phase_d == 2'd0) begin
               tx_d = P_ID_CODE[cnt_d[5:0]];
            end else if (phase_d == 2'd1) begin
               tx_d = ~P_ID_CODE[cnt_d[5:0]];
            end
         end
         ST_SP_RD: begin
            if (cnt_d < 7'd64) begin
               tx_d = sp_vec[cnt_d[5:0]];
            end else if (cnt_d < 7'd72) begin
               tx_d = crc[cnt_d[2:0]];
            end
         end
         // Line-powered: master holds the line high and times it
         ST_POLL:  tx_d = ext_q ? ~busy_d : 1'b1;
         ST_PWR:   tx_d = ext_q;
         default:  tx_d = 1'b1;
      endcase
   end

   always_ff @(posedge i_clock) begin
      ext_s1_q <= i_ext_powered;
      ext_q    <= ext_s1_q;
      if (i_srst) begin
         state_q <= ST_DEAD;
         cnt_q   <= '0;
         phase_q <= '0;
         rx_q    <= '0;
         busy_q  <= 1'b0;
         conv_q  <= '0;
         temp_q  <= TEMP_RESET;
         sp_q    <= '{cfg: CFG_RESET, lower: LOWER_RESET,
                      upper: UPPER_RESET};
         nv_q    <= '{cfg: CFG_RESET, lower: LOWER_RESET,
                      upper: UPPER_RESET};
         tx_q    <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         phase_q <= phase_d;
         rx_q    <= rx_d;
         busy_q  <= busy_d;
         conv_q  <= conv_d;
         temp_q  <= temp_d;
         sp_q    <= sp_d;
         nv_q    <= nv_d;
         tx_q    <= tx_d;
      end
   end

   assign o_rd_bit      = tx_q;
   assign o_conv_busy   = busy_q;
   assign o_temperature = temp_q;
   assign o_alarm       = alarm;

   // ==================================================================
   // Assertions
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   chk_conv_by_cmd: assert property (
      $rose(busy_q) |-> $past(conv_start))
      else $error("conversion began without command");
   chk_idle_power_up: assert property (
      $past(i_srst) |-> !busy_q && !conv_start)
      else $error("busy after reset");
   chk_default_res: assert property (
      $past(i_srst) |-> res == 2'b11)
      else $error("default resolution not 12 bit");
   chk_result_stored: assert property (
      busy_q && conv_q == 32'd1 |=> !busy_q && temp_q == $past(sample))
      else $error("result not stored at end");
   chk_mask_nine: assert property (
      $fell(busy_q) && $past(res) == 2'b00 |-> temp_q[2:0] == 3'b000)
      else $error("undefined bits not cleared");
   chk_sign_repeat: assert property (
      temp_q[15:11] == {5{temp_q[11]}})
      else $error("sign bits differ");
   chk_write_bytes: assert property (
      wr_done |=> sp_q.upper == $past(rx_d[7:0]) &&
                  sp_q.lower == $past(rx_d[15:8]))
      else $error("write bytes not stored");
   chk_copy_nv: assert property (
      copy_ev |=> nv_q == $past(sp_q))
      else $error("copy did not reach nonvolatile");
   chk_reload_wm: assert property (
      reload_ev |=> sp_q == $past(nv_q))
      else $error("reload did not reach working memory");
   chk_poll_answer: assert property (
      state_q == ST_POLL && ext_q && busy_q |-> !o_rd_bit)
      else $error("poll reads 1 while busy");
   chk_pwr_answer: assert property (
      state_q == ST_PWR ##1 state_q == ST_PWR |-> o_rd_bit == $past(ext_q))
      else $error("power answer wrong");
   chk_unselected: assert property (
      state_q == ST_DEAD |-> o_rd_bit && !conv_start)
      else $error("acting while unselected");

   cov_conversion: cover property ($fell(busy_q));
   cov_sp_read: cover property (state_q == ST_SP_RD && cnt_q == 7'd71);
   cov_search_done: cover property (state_q == ST_SEARCH ##1
                                    state_q == ST_FUNC);
endmodule // thm_core

// ==== bench/thm_master.sv ====
// Bus master model: reset pulses and bit slots toward the core.
// Assumes the core samples slots on rising edges of i_clock.
`timescale 1ns/1ns
module thm_master (
   // Clock
   input  wire logic i_clock,
   // Slot side
   input  wire logic i_rd_bit,
   output logic      o_bus_reset,
   output logic      o_wr_slot,
   output logic      o_wr_bit,
   output logic      o_rd_slot
);
   // ==================================================================
   // Slot primitives, driven on falling edges
   initial begin
      o_bus_reset = 1'b0;
      o_wr_slot   = 1'b0;
      o_wr_bit    = 1'b0;
      o_rd_slot   = 1'b0;
   end
   // Every transaction opens with a reset pulse
   task automatic bus_reset();
      @(negedge i_clock) o_bus_reset = 1'b1;
      @(negedge i_clock) o_bus_reset = 1'b0;
   endtask
   task automatic put_bit(input logic b);
      @(negedge i_clock);
      o_wr_bit  = b;
      o_wr_slot = 1'b1;
      @(negedge i_clock);
      o_wr_slot = 1'b0;
      // Released line must not look like the last bit
      o_wr_bit  = ~b;
   endtask
   task automatic get_bit(output logic b);
      @(negedge i_clock);
      b         = i_rd_bit;
      o_rd_slot = 1'b1;
      @(negedge i_clock);
      o_rd_slot = 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         put_bit(v[i]);
   endtask
   task automatic get_byte(output logic [7:0] v);
      for (int i = 0; i < 8; i++)
         get_bit(v[i]);
   endtask
   task automatic put_id(input logic [63:0] v);
      for (int i = 0; i < 8; i++)
         put_byte(v[8*i +: 8]);
   endtask
   // No slots while a line-powered conversion runs
   task automatic hold(input int n);
      repeat (n) @(negedge i_clock);
   endtask
endmodule // thm_master

// ==== bench/thm_core_tb.sv ====
// Self-checking bench of the thermometer command core.
// Assumes thm_master stands in for the bit-slot layer and bus master.
`timescale 1ns/1ns
module thm_core_tb;
   import thm_pkg::*;
   localparam logic [63:0] ID   = 64'h5A3C_9E01_77B2_4D28; // Arbitrary
   localparam int unsigned CONV = 64;
   logic        i_clock, i_srst, i_bus_reset, i_wr_slot, i_wr_bit;
   logic        i_rd_slot, o_rd_bit, i_ext_powered;
   logic        o_conv_busy, o_alarm;
   logic [15:0] i_sensor_temp, o_temperature;
   int          n_fail, total_checks, busy_n;
   logic        a;
   logic [7:0]  v;

   thm_core #(.P_ID_CODE(ID), .P_CONV_CYCLES(CONV)) dut (
      .i_clock(i_clock), .i_srst(i_srst), .i_bus_reset(i_bus_reset),
      .i_wr_slot(i_wr_slot), .i_wr_bit(i_wr_bit), .i_rd_slot(i_rd_slot),
      .o_rd_bit(o_rd_bit), .i_sensor_temp(i_sensor_temp),
      .i_ext_powered(i_ext_powered), .o_conv_busy(o_conv_busy),
      .o_temperature(o_temperature), .o_alarm(o_alarm));
   thm_master m (.i_clock(i_clock), .i_rd_bit(o_rd_bit),
      .o_bus_reset(i_bus_reset), .o_wr_slot(i_wr_slot),
      .o_wr_bit(i_wr_bit), .o_rd_slot(i_rd_slot));

   // ==================================================================
   // Clock, busy counter, watchdog
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) if (o_conv_busy === 1'b1) busy_n <= busy_n + 1;
   initial begin
      repeat (60000) @(posedge i_clock);
      n_fail++;
      tally_and_finish();
   end

   // ==================================================================
   // Helpers
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [7:0] crc8(input logic [63:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 64; i++)
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
      return c;
   endfunction
   task automatic sel_cmd(input logic [7:0] c);
      m.bus_reset();
      m.put_byte(CMD_ID_SKIP);
      m.put_byte(c);
   endtask
   task automatic wr_mem(input logic [7:0] u, l, g);
      sel_cmd(CMD_SP_WRITE);
      m.put_byte(u);
      m.put_byte(l);
      m.put_byte(g);
   endtask
   task automatic mem_check(input logic [15:0] t, input logic [7:0] u, l, g);
      logic [63:0] e;
      logic [7:0]  x;
      e = {RSV_BYTE7, RSV_BYTE6, RSV_BYTE5, g, l, u, t};
      sel_cmd(CMD_SP_READ);
      for (int i = 0; i < 8; i++) begin
         m.get_byte(x);
         check(x, e[8*i +: 8]);
      end
      m.get_byte(x);
      check(x, crc8(e));
   endtask
   task automatic search(input logic [7:0] c, input logic part);
      logic p, q;
      m.bus_reset();
      m.put_byte(c);
      for (int i = 0; i < 64; i++) begin
         m.get_bit(p);
         m.get_bit(q);
         check({p, q}, part ? {ID[i], ~ID[i]} : 2'b11);
         m.put_bit(ID[i]);
      end
   endtask
   task automatic convert();
      busy_n = 0;
      sel_cmd(CMD_CONVERT);
      m.get_bit(a);
      check(a, 1'b0);
      for (int n = 0; o_conv_busy !== 1'b0 && n < 2000; n++)
         @(negedge i_clock);
      m.get_bit(a);
      check(a, 1'b1);
   endtask
   task automatic match(input logic [63:0] id, input logic [7:0] e);
      m.bus_reset();
      m.put_byte(CMD_ID_MATCH);
      m.put_id(id);
      m.put_byte(CMD_SP_READ);
      m.get_byte(v);
      check(v, e);
   endtask

   // ==================================================================
   // Scenarios
   initial begin
      n_fail = 0;
      total_checks = 0;
      busy_n = 0;
      i_srst = 1'b1;
      i_ext_powered = 1'b1;
      i_sensor_temp = 16'h01A7;
      // Count rising edges: the time-zero clock start is no edge
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      i_srst = 1'b0;
      check(o_conv_busy, 1'b0);
      check(o_temperature, TEMP_RESET);
      m.bus_reset();
      m.put_byte(CMD_SP_READ);
      m.get_byte(v);
      check(v, 8'hFF);
      m.bus_reset();
      m.put_byte(CMD_ID_READ);
      for (int i = 0; i < 8; i++) begin
         m.get_byte(v);
         check(v, ID[8*i +: 8]);
      end
      match(ID, TEMP_RESET[7:0]);
      match(ID ^ 64'h0000_0000_0000_0100, 8'hFF);
      mem_check(TEMP_RESET, UPPER_RESET, LOWER_RESET, CFG_RESET);
      sel_cmd(CMD_PWR_QUERY);
      m.get_bit(a);
      check(a, 1'b1);
      for (int r = 0; r < 4; r++) begin
         wr_mem(8'h7D, 8'hC9, {1'b0, r[1:0], 5'h00});
         convert();
         check(busy_n >= (CONV >> (3 - r)) - 1 &&
               busy_n <= (CONV >> (3 - r)) + 1, 1'b1);
         mem_check(16'h01A7 & (16'hFFFF << (3 - r)), 8'h7D, 8'hC9,
                   {1'b0, r[1:0], 5'h1F});
      end
      i_sensor_temp = 16'hFF5E;
      convert();
      check(o_temperature, 16'hFF5E);
      check(o_alarm, 1'b0);
      search(CMD_ALM_SRCH, 1'b0);
      search(CMD_SEARCH, 1'b1);
      wr_mem(8'hF0, 8'hC9, 8'h7F);
      check(o_alarm, 1'b1);
      search(CMD_ALM_SRCH, 1'b1);
      sel_cmd(CMD_COPY);
      m.hold(4);
      wr_mem(8'h11, 8'h22, 8'h00);
      mem_check(16'hFF5E, 8'h11, 8'h22, 8'h1F);
      sel_cmd(CMD_RELOAD);
      mem_check(16'hFF5E, 8'hF0, 8'hC9, 8'h7F);
      i_ext_powered = 1'b0;
      m.hold(4);
      sel_cmd(CMD_PWR_QUERY);
      m.get_bit(a);
      check(a, 1'b0);
      // Line-powered conversion: no busy answer, master times it
      sel_cmd(CMD_CONVERT);
      m.get_bit(a);
      check({a, o_conv_busy}, 2'b11);
      m.hold(CONV + 2);
      check(o_conv_busy, 1'b0);
      check(o_temperature, 16'hFF5E);
      tally_and_finish();
   end
endmodule // thm_core_tb
